// [rtl/ccs_pkg.sv]
// Constants for the converter configuration and event-flag registers.
// Assumes a byte-wide register port with 8-bit addresses.
package ccs_pkg;
    localparam logic [7:0] CONFIG_ADDR      = 8'h03;
    localparam logic [7:0] FLAGS_ADDR       = 8'h04;
    localparam logic [7:0] FLAGS_RESET      = 8'h00;
    // Droop bit of the config reset value comes from the factory option
    localparam logic [7:0] CONFIG_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_WR_MASK   = 8'h07;
    localparam int         DROOP_BIT        = 2;
    localparam int         STANDALONE_BIT   = 1;
    localparam int         PG_BLANK_BIT     = 0;
    localparam int         EVENT_COUNT      = 6;
endpackage

// [rtl/ccs_regs.sv]
// Configuration and sticky event-flag registers of a step-down converter.
// Assumes the host port logic delivers single-cycle read and write strobes
// on ref_clk_i; analog event inputs arrive asynchronously.
//
// Behaviour
// - config bit 2 enables droop compensation
// - config bit 1 disables pulldown and sync
// - config bit 0 blanks power-good during scaling
// - flag bits 7-6 read as zero
// - flag bit 5 records hiccup until read
// - flag bit 4 records current limit
// - flag bit 3 records thermal warning
// - flag bit 2 records thermal shutdown
// - flag bit 1 records undervoltage
// - flag bit 0 records overvoltage
// - flags at address 4, reset zero
// - configuration register at address 3
`timescale 1ns/1ps
module ccs_regs
#(
    parameter logic DROOP_DEFAULT = 1'b0
)
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Asynchronous event inputs
    input  wire logic       hiccup_evt_i,
    input  wire logic       current_limit_evt_i,
    input  wire logic       thermal_warning_evt_i,
    input  wire logic       thermal_shutdown_evt_i,
    input  wire logic       undervoltage_evt_i,
    input  wire logic       overvoltage_evt_i,
    // Controls to the converter
    output logic            droop_comp_enable_o,
    output logic            en_pulldown_enable_o,
    output logic            clock_sync_output_enable_o,
    input  wire logic       dynamic_voltage_scaling_i,
    input  wire logic       window_ok_i,
    output logic            power_good_output_o,
    output logic            power_good_output_oe_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] droop_single_pg_config;
    logic [5:0] event_flags;
    logic [5:0] evt_meta;
    logic [5:0] evt_sync;
    logic [5:0] evt_prev;
    logic       dvs_meta;
    logic       dvs_sync;
    logic       win_meta;
    logic       win_sync;

    // Reserved bits reset to zero; droop bit follows the factory option
    localparam logic [7:0] CONFIG_RESET_VAL = ccs_pkg::CONFIG_RESET |
                                              (8'(DROOP_DEFAULT) << ccs_pkg::DROOP_BIT);

    wire        config_sel = (addr_i == ccs_pkg::CONFIG_ADDR);
    wire        config_wr  = wr_i && config_sel;
    wire        flags_sel  = (addr_i == ccs_pkg::FLAGS_ADDR);
    wire        flags_rd   = rd_i && flags_sel;
    wire [5:0]  evt_raw    = {hiccup_evt_i, current_limit_evt_i, thermal_warning_evt_i,
                              thermal_shutdown_evt_i, undervoltage_evt_i, overvoltage_evt_i};
    wire [5:0]  evt_rise   = evt_sync & ~evt_prev;
    // Reserved bits kept as written so software sees what it wrote
    wire [7:0]  next_config = wdata_i;
    wire [7:0]  flags_word  = {2'b00, event_flags};
    wire [7:0]  next_rdata  = config_sel ? droop_single_pg_config :
                              flags_sel  ? flags_word : 8'h00;
    wire        blank       = droop_single_pg_config[ccs_pkg::PG_BLANK_BIT] && dvs_sync;
    wire        standalone  = droop_single_pg_config[ccs_pkg::STANDALONE_BIT];

    // Flag vector and event ports are sized for six events
    if (ccs_pkg::EVENT_COUNT != 6)
    begin : g_bad_event_count
        $error("six event flags expected");
    end

    ////////////////////////////////////////////////////////////////////////
    // Event inputs pass two flops before edge detection
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            evt_meta <= 6'h00;
            evt_sync <= 6'h00;
            evt_prev <= 6'h00;
            dvs_meta <= 1'b0;
            dvs_sync <= 1'b0;
            win_meta <= 1'b0;
            win_sync <= 1'b0;
        end
        else
        begin
            evt_meta <= evt_raw;
            evt_sync <= evt_meta;
            evt_prev <= evt_sync;
            dvs_meta <= dynamic_voltage_scaling_i;
            dvs_sync <= dvs_meta;
            win_meta <= window_ok_i;
            win_sync <= win_meta;
        end
    end

    // Sticky flags: a new event wins over the clear of a read
    genvar g;
    generate
        for (g = 0; g < ccs_pkg::EVENT_COUNT; g++)
        begin : g_flag
            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    event_flags[g] <= ccs_pkg::FLAGS_RESET[g];
                else if (evt_rise[g])
                    event_flags[g] <= 1'b1;
                else if (flags_rd)
                    event_flags[g] <= 1'b0;
            end
            a_flag_kept: assert property (@(posedge ref_clk_i) disable iff (rst_i)
                (event_flags[g] && !flags_rd) |=> event_flags[g])
                else $error("event flag lost without a read");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Factory droop option is part of the reset value, so no write after reset is lost
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
            droop_single_pg_config <= CONFIG_RESET_VAL;
        else if (config_wr)
            droop_single_pg_config <= next_config;
    end

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o                    <= 8'h00;
            droop_comp_enable_o        <= DROOP_DEFAULT;
            en_pulldown_enable_o       <= 1'b1;
            clock_sync_output_enable_o <= 1'b1;
            power_good_output_o        <= 1'b0;
            power_good_output_oe_o     <= 1'b1;
        end
        else
        begin
            if (rd_i)
                rdata_o <= next_rdata;
            droop_comp_enable_o        <= droop_single_pg_config[ccs_pkg::DROOP_BIT];
            en_pulldown_enable_o       <= !standalone;
            clock_sync_output_enable_o <= !standalone;
            // Open drain: pull low when window says bad and blanking is not active, released otherwise
            power_good_output_o        <= 1'b0;
            power_good_output_oe_o     <= !blank && !win_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag set and hold
    a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (event_flags[5] && !flags_rd) |=> event_flags[5])
        else $error("hiccup flag lost without a read");
    a_current_limit_flag_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_rise[4] |=> event_flags[4])
        else $error("current limit flag not set");
    a_thermal_warning_flag_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(evt_sync[3]) |=> event_flags[3])
        else $error("thermal warning flag not set");
    a_thermal_shutdown_flag_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_rise[2] |=> event_flags[2])
        else $error("thermal shutdown flag not set");
    a_uv_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_rise[1] |=> event_flags[1])
        else $error("undervoltage flag not set");
    a_ov_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        evt_rise[0] |=> event_flags[0])
        else $error("overvoltage flag not set");

    // Read port
    a_read_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (flags_rd && evt_rise == 6'h00) |=> (event_flags == 6'h00 && rdata_o == {2'b00, $past(event_flags)}))
        else $error("flags read did not return then clear");
    a_reserved_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $past(flags_rd) |-> rdata_o[7:6] == 2'b00)
        else $error("reserved flag bits not zero");
    a_rdata_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !rd_i |=> $stable(rdata_o))
        else $error("read data changed without a read");
    a_cfg_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        config_wr |=> droop_single_pg_config == $past(wdata_i))
        else $error("configuration write not stored");

    // Configuration outputs
    a_standalone_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        config_wr |-> ##2 (en_pulldown_enable_o == !$past(wdata_i[ccs_pkg::STANDALONE_BIT], 2)))
        else $error("standalone bit not applied");
    a_pd_sync_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> {en_pulldown_enable_o, clock_sync_output_enable_o} == {2{!$past(standalone)}})
        else $error("pulldown or sync enable mismatch");
    a_droop_out: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> droop_comp_enable_o == $past(droop_single_pg_config[ccs_pkg::DROOP_BIT]))
        else $error("droop output mismatch");

    // Power-good pin
    a_pg_blank: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        blank |=> !power_good_output_oe_o)
        else $error("power good not released while blanked");
    a_pg_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !droop_single_pg_config[ccs_pkg::PG_BLANK_BIT] |=> power_good_output_oe_o == !$past(win_sync))
        else $error("power good does not follow the window");
    a_pg_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        power_good_output_o == 1'b0)
        else $error("power good drives high");

endmodule

// [testbench/ccs_host.sv]
// Host model: drives the byte-wide register port.
// Assumes strobes are taken on the rising edge of ref_clk_i.
`timescale 1ns/1ps
module ccs_host
#(
    parameter bit STACKED = 1'b0
)
(
    // Clock
    input  wire logic       ref_clk_i,
    // Register port
    output logic      [7:0] addr_o  = 8'hFF,
    output logic      [7:0] wdata_o = 8'hFF,
    output logic            wr_o    = 1'b0,
    output logic            rd_o    = 1'b0,
    input  wire logic [7:0] rdata_i
);
    ////////////////////////////////////////////////////////////////
    // Idle bus shows inverted values, never the last ones
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        addr_o  = a;
        // A stacked converter keeps the standalone bit clear
        wdata_o = d & ccs_pkg::CONFIG_WR_MASK & ~(8'(STACKED) << ccs_pkg::STANDALONE_BIT);
        wr_o    = 1'b1;
        @(posedge ref_clk_i);
        #1;
        wr_o    = 1'b0;
        addr_o  = ~a;
        wdata_o = ~wdata_o;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        #1;
        addr_o = a;
        rd_o   = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rd_o   = 1'b0;
        addr_o = ~a;
        d      = rdata_i;
    endtask
endmodule

// [testbench/test_ccs_regs.sv]
// Bench: config outputs, power-good blanking, sticky flags.
// Assumes the host model ccs_host.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t bad value", $time); end end
module test_ccs_regs;
    logic       ref_clk_i = 1'b0;
    logic       rst_i     = 1'b1;
    logic [5:0] evt       = 6'h00;
    logic       dynamic_voltage_scaling       = 1'b0;
    logic       win       = 1'b1;
    logic [7:0] addr, wdata, rdata, r1, r2, r3;
    logic       wr, rd, droop, pd, sync, pg, pg_oe;
    int         n_fail    = 0;
    int         tests_run = 0;
    int         cyc       = 0;
    // Non-default factory option so the droop reset value is exercised
    localparam logic DROOP_DEF = 1'b1;
    always #5 ref_clk_i = ~ref_clk_i;
    ccs_host u_host (.ref_clk_i(ref_clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));
    ccs_regs #(.DROOP_DEFAULT(DROOP_DEF)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hiccup_evt_i(evt[5]),
        .current_limit_evt_i(evt[4]), .thermal_warning_evt_i(evt[3]),
        .thermal_shutdown_evt_i(evt[2]), .undervoltage_evt_i(evt[1]), .overvoltage_evt_i(evt[0]),
        .droop_comp_enable_o(droop), .en_pulldown_enable_o(pd), .clock_sync_output_enable_o(sync),
        .dynamic_voltage_scaling_i(dynamic_voltage_scaling), .window_ok_i(win), .power_good_output_o(pg), .power_good_output_oe_o(pg_oe));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic settle();
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic t_reset();
        `CHK({droop, pd, sync}, {DROOP_DEF, 2'b11})
        u_host.rd_reg(ccs_pkg::CONFIG_ADDR, r1);
        `CHK(r1, {5'h00, DROOP_DEF, 2'b00})
        u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r1);
        `CHK(r1, 8'h00)
        u_host.rd_reg(8'h05, r1);
        `CHK(r1, 8'h00)
        $display("t_reset done");
    endtask
    task automatic t_config();
        for (int i = 0; i < 8; i++)
        begin
            u_host.wr_reg(ccs_pkg::CONFIG_ADDR, 8'(i));
            u_host.rd_reg(ccs_pkg::CONFIG_ADDR, r1);
            `CHK(r1, 8'(i))
            `CHK(droop, logic'(i[2]))
            `CHK({pd, sync}, {2{!i[1]}})
        end
        // Blanking set, window lost during a transition
        win = 1'b0;
        dynamic_voltage_scaling = 1'b1;
        settle();
        `CHK(pg_oe, 1'b0)
        // Blanking only acts during a transition
        dynamic_voltage_scaling = 1'b0;
        settle();
        `CHK(pg_oe, 1'b1)
        dynamic_voltage_scaling = 1'b1;
        u_host.wr_reg(ccs_pkg::CONFIG_ADDR, 8'h00);
        settle();
        `CHK({pg_oe, pg}, 2'b10)
        win = 1'b1;
        dynamic_voltage_scaling = 1'b0;
        settle();
        `CHK(pg_oe, 1'b0)
        $display("t_config done");
    endtask
    task automatic t_flags();
        for (int i = 0; i < 6; i++)
        begin
            evt[i] = 1'b1;
            settle();
            u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r1);
            `CHK(r1, 8'h01 << i)
            u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r1);
            `CHK(r1, 8'h00)
            evt[i] = 1'b0;
        end
        $display("t_flags done");
    endtask
    // Event lands at varying offsets around a read; it must show once
    task automatic t_race();
        // Input chain must idle low first, or the first rise is missed
        settle();
        for (int k = 0; k < 5; k++)
        begin
            evt[5] = 1'b1;
            repeat (k) @(posedge ref_clk_i);
            u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r1);
            u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r2);
            u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r3);
            `CHK({r1[5], r2[5], r3[5]}, (k < 2) ? 3'b010 : 3'b100)
            evt[5] = 1'b0;
            settle();
        end
        $display("t_race done");
    endtask
    // Reset in mid-run drops written config, pending flags and read data
    task automatic t_rereset();
        u_host.wr_reg(ccs_pkg::CONFIG_ADDR, 8'h03);
        u_host.rd_reg(ccs_pkg::CONFIG_ADDR, r1);
        `CHK(r1, 8'h03)
        evt[0] = 1'b1;
        settle();
        evt[0] = 1'b0;
        rst_i  = 1'b1;
        @(posedge ref_clk_i);
        #1;
        `CHK({droop, pd, sync, pg_oe, pg, rdata}, {DROOP_DEF, 4'b1110, 8'h00})
        rst_i  = 1'b0;
        settle();
        u_host.rd_reg(ccs_pkg::FLAGS_ADDR, r1);
        `CHK(r1, ccs_pkg::FLAGS_RESET)
        u_host.rd_reg(ccs_pkg::CONFIG_ADDR, r1);
        `CHK(r1, {5'h00, DROOP_DEF, 2'b00})
        $display("t_rereset done");
    endtask
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        settle();
        t_reset();
        t_config();
        t_flags();
        t_race();
        t_rereset();
        give_verdict();
    end
endmodule
